// [hw/clk_ctl.sv]
// System clock generator with speed modes, stop and wait handling, over AXI4-Lite
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module clk_ctl
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [clk_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [clk_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Oscillator pins
  input wire logic main_osc_in,
  input wire logic sub_osc_in,
  output logic main_osc_en,
  output logic sub_osc_en,
  output logic sub_pins_port_mode,
  // Interrupts
  input wire logic ext_irq,
  input wire logic irq_accept,
  // Internal clock
  output logic phi,
  output logic cpu_clk_held
);

  logic [2:0] main_s;
  logic [2:0] sub_s;
  logic [2:0] irq_s;
  logic main_l;
  logic sub_l;
  logic irq_l;
  logic main_rise;
  logic sub_rise;

  logic [7:0] misc_reg;
  logic [7:0] mode_reg;
  logic [7:0] pre_reg;
  logic [7:0] tmr_reg;
  logic [7:0] pre_rel_reg;
  logic [7:0] tmr_rel_reg;
  logic src_lat_reg;
  logic [3:0] rec_div_reg;
  logic [1:0] half_cnt_reg;
  clk_ctl_pkg::spd_t cur_spd_reg;
  clk_ctl_pkg::spd_t pend_spd;
  clk_ctl_pkg::state_t state_reg;

  logic aw_got;
  logic w_got;
  logic [7:0] aw_idx;
  logic aw_ok;
  logic [7:0] wbyte;
  logic wbyte_en;
  logic wr_fire;
  logic wr_misc;
  logic wr_mode;
  logic wr_pre;
  logic wr_tmr;
  logic wr_cmd;
  logic rd_fire;
  logic [7:0] ar_idx;
  logic [7:0] rd_byte;
  logic rd_ok;

  logic src_rise;
  logic toggle_ev;
  logic rec_tick;
  logic underflow;
  logic go_stop;
  logic go_wait;

  // Pin synchronisers: a level counts once the second and third stages agree
  always_ff @(posedge aclk)
  begin
    main_s <= {main_s[1:0], main_osc_in};
    sub_s <= {sub_s[1:0], sub_osc_in};
    irq_s <= {irq_s[1:0], ext_irq};
    if (!aresetn)
    begin
      // Track the resting oscillator pin level, so a pin parked high gives no false edge after reset
      main_l <= main_s[2];
      sub_l <= sub_s[2];
      irq_l <= 1'b0;
    end
    else
    begin
      if (main_s[1] == main_s[2])
        main_l <= main_s[2];
      if (sub_s[1] == sub_s[2])
        sub_l <= sub_s[2];
      if (irq_s[1] == irq_s[2])
        irq_l <= irq_s[2];
    end
  end

  assign main_rise = (main_s[1] == main_s[2]) && main_s[2] && !main_l;
  assign sub_rise = (sub_s[1] == sub_s[2]) && sub_s[2] && !sub_l;

  // Write channel: each ready is a one-cycle pulse, address and data taken in either order
  assign aw_idx = s_axi_awaddr[9:2];
  assign aw_ok = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr[11:10] == 2'h0) &&
    (aw_idx == clk_ctl_pkg::IDX_MISC || aw_idx == clk_ctl_pkg::IDX_PRE ||
     aw_idx == clk_ctl_pkg::IDX_TMR || aw_idx == clk_ctl_pkg::IDX_MODE ||
     aw_idx == clk_ctl_pkg::IDX_CMD || aw_idx == clk_ctl_pkg::IDX_STAT);

  logic [7:0] awi_reg;
  logic awok_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awi_reg <= 8'h00;
      awok_reg <= 1'b0;
      wbyte <= 8'h00;
      wbyte_en <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= clk_ctl_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_got && !s_axi_bvalid;
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_got && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        awi_reg <= aw_idx;
        awok_reg <= aw_ok;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        wbyte <= s_axi_wdata[7:0];
        wbyte_en <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awok_reg ? clk_ctl_pkg::RESP_OKAY : clk_ctl_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign wr_fire = aw_got && w_got && !s_axi_bvalid;
  assign wr_misc = wr_fire && awok_reg && wbyte_en && awi_reg == clk_ctl_pkg::IDX_MISC;
  assign wr_mode = wr_fire && awok_reg && wbyte_en && awi_reg == clk_ctl_pkg::IDX_MODE;
  assign wr_pre = wr_fire && awok_reg && wbyte_en && awi_reg == clk_ctl_pkg::IDX_PRE;
  assign wr_tmr = wr_fire && awok_reg && wbyte_en && awi_reg == clk_ctl_pkg::IDX_TMR;
  assign wr_cmd = wr_fire && awok_reg && wbyte_en && awi_reg == clk_ctl_pkg::IDX_CMD;

  // Read channel
  assign ar_idx = s_axi_araddr[9:2];
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[11:10] == 2'h0);
    rd_byte = 8'h00;
    unique case (ar_idx)
      clk_ctl_pkg::IDX_MISC: rd_byte = misc_reg;
      clk_ctl_pkg::IDX_PRE: rd_byte = pre_reg;
      clk_ctl_pkg::IDX_TMR: rd_byte = tmr_reg;
      clk_ctl_pkg::IDX_MODE: rd_byte = mode_reg;
      clk_ctl_pkg::IDX_CMD: rd_byte = 8'h00;
      clk_ctl_pkg::IDX_STAT: rd_byte = {1'b0, sub_osc_en, main_osc_en, phi, cur_spd_reg, state_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= clk_ctl_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_ok ? rd_byte : 8'h00};
        s_axi_rresp <= rd_ok ? clk_ctl_pkg::RESP_OKAY : clk_ctl_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Control registers; reset selects middle speed with the sub oscillator off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      misc_reg <= clk_ctl_pkg::MISC_RST;
      mode_reg <= clk_ctl_pkg::MODE_RST;
    end
    else
    begin
      if (wr_misc)
        misc_reg <= wbyte;
      if (wr_mode)
        mode_reg <= wbyte;
    end
  end

  // Unused speed code 3 falls back to middle speed
  always_comb
  begin
    unique case (mode_reg[clk_ctl_pkg::MODE_SPD_LSB +: 2])
      2'h1: pend_spd = clk_ctl_pkg::SPD_HIGH;
      2'h2: pend_spd = clk_ctl_pkg::SPD_LOW;
      default: pend_spd = clk_ctl_pkg::SPD_MID;
    endcase
  end

  // Instructions arrive as command writes; stop wins over wait
  assign go_stop = wr_cmd && wbyte[clk_ctl_pkg::CMD_STOP_BIT] && state_reg == clk_ctl_pkg::ST_RUN;
  assign go_wait = wr_cmd && wbyte[clk_ctl_pkg::CMD_WAIT_BIT] && !wbyte[clk_ctl_pkg::CMD_STOP_BIT] &&
    state_reg == clk_ctl_pkg::ST_RUN;

  // Recovery count source: main / 16, or the sub oscillator if chosen when stop was entered
  assign rec_tick = state_reg == clk_ctl_pkg::ST_RECOVER &&
    (src_lat_reg ? sub_rise : (main_rise && rec_div_reg == clk_ctl_pkg::REC_DIV_LAST));
  assign underflow = rec_tick && pre_reg == 8'h00 && tmr_reg == 8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rec_div_reg <= 4'h0;
    else if (state_reg != clk_ctl_pkg::ST_RECOVER)
      rec_div_reg <= 4'h0;
    else if (main_rise)
      rec_div_reg <= rec_div_reg + 4'h1;
  end

  // Prescaler and timer: software preload, stop-entry load, recovery countdown
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_reg <= clk_ctl_pkg::PRE_RST;
      tmr_reg <= clk_ctl_pkg::TMR_RST;
      pre_rel_reg <= clk_ctl_pkg::PRE_RST;
      tmr_rel_reg <= clk_ctl_pkg::TMR_RST;
      src_lat_reg <= 1'b0;
    end
    else if (go_stop)
    begin
      src_lat_reg <= misc_reg[clk_ctl_pkg::MISC_SRC_BIT];
      if (!misc_reg[clk_ctl_pkg::MISC_STAB_BIT])
      begin
        pre_reg <= clk_ctl_pkg::PRE_STOP_LOAD;
        tmr_reg <= clk_ctl_pkg::TMR_STOP_LOAD;
        pre_rel_reg <= clk_ctl_pkg::PRE_STOP_LOAD;
        tmr_rel_reg <= clk_ctl_pkg::TMR_STOP_LOAD;
      end
      // Otherwise the software preload stands untouched
    end
    else if (rec_tick)
    begin
      if (pre_reg != 8'h00)
        pre_reg <= pre_reg - 8'h01;
      else
      begin
        pre_reg <= pre_rel_reg;
        tmr_reg <= (tmr_reg == 8'h00) ? tmr_rel_reg : tmr_reg - 8'h01;
      end
    end
    else
    begin
      if (wr_pre)
      begin
        pre_reg <= wbyte;
        pre_rel_reg <= wbyte;
      end
      if (wr_tmr)
      begin
        tmr_reg <= wbyte;
        tmr_rel_reg <= wbyte;
      end
    end
  end

  // Standby state; reset leaves any state at once with no wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= clk_ctl_pkg::ST_RUN;
    else
    begin
      unique case (state_reg)
        clk_ctl_pkg::ST_RUN:
          if (go_stop)
            state_reg <= clk_ctl_pkg::ST_STOP;
          else if (go_wait)
            state_reg <= clk_ctl_pkg::ST_WAIT;
        clk_ctl_pkg::ST_WAIT:
          if (irq_accept || irq_l)
            state_reg <= clk_ctl_pkg::ST_RUN;
        clk_ctl_pkg::ST_STOP:
          if (irq_l)
            state_reg <= clk_ctl_pkg::ST_RECOVER;
        clk_ctl_pkg::ST_RECOVER:
          if (underflow)
            state_reg <= clk_ctl_pkg::ST_RUN;
      endcase
    end
  end

  // Oscillator enables; stop only cuts them once the clock is parked high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_osc_en <= 1'b1;
      sub_osc_en <= 1'b0;
      sub_pins_port_mode <= 1'b1;
    end
    else
    begin
      main_osc_en <= !((mode_reg[clk_ctl_pkg::MODE_MSTOP_BIT] && cur_spd_reg == clk_ctl_pkg::SPD_LOW) ||
        (state_reg == clk_ctl_pkg::ST_STOP && phi));
      sub_osc_en <= mode_reg[clk_ctl_pkg::MODE_SUB_EN_BIT] && !(state_reg == clk_ctl_pkg::ST_STOP && phi);
      sub_pins_port_mode <= !mode_reg[clk_ctl_pkg::MODE_SUB_EN_BIT];
    end
  end

  // Clock generation: toggle on source edges, middle speed every fourth main edge
  assign src_rise = (cur_spd_reg == clk_ctl_pkg::SPD_LOW) ? sub_rise : main_rise;
  assign toggle_ev = src_rise &&
    (cur_spd_reg != clk_ctl_pkg::SPD_MID || half_cnt_reg == clk_ctl_pkg::MID_HALF_LAST);

  // A speed change is applied only while the clock is high at an edge of the old source,
  // and the high phase then runs on to the next toggle edge of the new one, so no short pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phi <= 1'b1;
      cur_spd_reg <= clk_ctl_pkg::SPD_MID;
      half_cnt_reg <= 2'h0;
      cpu_clk_held <= 1'b0;
    end
    else
    begin
      cpu_clk_held <= state_reg != clk_ctl_pkg::ST_RUN;
      if (src_rise && cur_spd_reg == clk_ctl_pkg::SPD_MID)
        half_cnt_reg <= half_cnt_reg + 2'h1;
      if (toggle_ev)
      begin
        if (!phi)
          phi <= 1'b1;
        else if (state_reg != clk_ctl_pkg::ST_RUN)
          phi <= 1'b1;
        else if (pend_spd != cur_spd_reg)
        begin
          cur_spd_reg <= pend_spd;
          half_cnt_reg <= 2'h0;
        end
        else
          phi <= 1'b0;
      end
    end
  end

endmodule

// [hw/clk_ctl_pkg.sv]
// Constants, register map and types for the system clock and standby control
// Notes on behaviour
// - Middle-speed mode makes the internal clock from the main oscillator divided by eight and is the mode after reset.
// - High-speed mode makes the internal clock at half the main oscillator frequency.
// - Low-speed mode makes the internal clock at half the sub oscillator frequency.
// - Setting the main clock stop bit halts the main oscillator for low-power running in low-speed mode; clearing it restarts it.
// - The stop instruction freezes the internal clock high and halts both oscillators.
// - With the stabilisation-select bit at zero, entering stop loads the prescaler with 0xFF and the timer with 0x01.
// - With the stabilisation-select bit at one, stop entry leaves prescaler and timer as software preloaded them.
// - After stop the prescaler counts the source chosen when stop was entered and its output clocks the timer.
// - An external interrupt in stop restarts the oscillators but holds the clock high until the timer underflows.
// - The wait instruction freezes the clock high with oscillators running and resumes at once on reset or interrupt.
// - Stop recovery counts the main oscillator divided by sixteen, or the sub oscillator if chosen; software disables the timer interrupt before stop.
// - After power on only the main oscillator runs and the sub oscillator pins serve as port pins.
package clk_ctl_pkg;

  localparam int ADDR_W = 12;

  // Printed offsets are not all word aligned: they are indices, byte address = 4 * index
  localparam logic [7:0] IDX_MISC = 8'h10;
  localparam logic [7:0] IDX_PRE = 8'h20;
  localparam logic [7:0] IDX_TMR = 8'h21;
  localparam logic [7:0] IDX_MODE = 8'h3B;
  localparam logic [7:0] IDX_CMD = 8'h40;
  localparam logic [7:0] IDX_STAT = 8'h41;

  localparam int MISC_STAB_BIT = 0;
  localparam int MISC_SRC_BIT = 1;
  localparam int MODE_SUB_EN_BIT = 4;
  localparam int MODE_MSTOP_BIT = 5;
  localparam int MODE_SPD_LSB = 6;
  localparam int CMD_STOP_BIT = 0;
  localparam int CMD_WAIT_BIT = 1;

  localparam logic [7:0] MISC_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PRE_RST = 8'hFF;
  localparam logic [7:0] TMR_RST = 8'h01;
  localparam logic [7:0] PRE_STOP_LOAD = 8'hFF;
  localparam logic [7:0] TMR_STOP_LOAD = 8'h01;

  // Main oscillator rising edges per half period of the internal clock in middle-speed mode, minus one
  localparam logic [1:0] MID_HALF_LAST = 2'h3;
  // Main oscillator rising edges per recovery count tick, minus one
  localparam logic [3:0] REC_DIV_LAST = 4'hF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SPD_MID, SPD_HIGH, SPD_LOW} spd_t;
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER} state_t;

endpackage

// [verif/clk_ctl_monitor.sv]
// Concurrent checks on the clock control block ports
`timescale 1ns/1ps
module clk_ctl_monitor
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Clock outputs
  input wire logic main_osc_en,
  input wire logic sub_osc_en,
  input wire logic sub_pins_port_mode,
  input wire logic phi,
  input wire logic cpu_clk_held
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awready && s_axi_wready;
  endsequence
  sequence s_resp_up;
    !s_axi_awready && s_axi_bvalid;
  endsequence

  // Reset itself is the cause here, so this one is never disabled
  a_reset_values: assert property (disable iff (1'b0) !aresetn |=> phi && main_osc_en && !sub_osc_en &&
    sub_pins_port_mode && !cpu_clk_held) else $error("outputs wrong after reset");
  a_port_pins: assert property (sub_osc_en |-> !sub_pins_port_mode) else $error("sub pins still port pins");
  a_stop_frozen: assert property (!main_osc_en && !sub_osc_en |-> phi && cpu_clk_held)
    else $error("oscillators off while clock not parked");
  a_held_park: assert property ($fell(phi) |-> ##[0:2] !cpu_clk_held)
    else $error("clock fell while held");
  a_no_glitch: assert property ($changed(phi) |=> $stable(phi) [*6]) else $error("short clock pulse");
  a_write_walk: assert property (s_wr_taken |=> ##1 s_resp_up) else $error("write response late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_walk: assert property (s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind clk_ctl clk_ctl_monitor i_clk_ctl_monitor (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .main_osc_en,
  .sub_osc_en, .sub_pins_port_mode, .phi, .cpu_clk_held);

// [verif/osc_model.sv]
// Resonator models on the main and sub oscillator pins
`timescale 1ns/1ps
module osc_model
(
  // Enables from the block
  input wire logic main_osc_en,
  input wire logic sub_osc_en,
  // Oscillator pins
  output logic main_osc_in,
  output logic sub_osc_in
);
  // Main runs about five times the sub rate, above the mode-switch margin
  localparam time MAIN_HALF = 163ns;
  localparam time SUB_HALF = 807ns;
  initial
  begin
    main_osc_in = 1'b0;
    sub_osc_in = 1'b0;
  end
  // Ideal resonators settle at once, so every restart is already stable
  always
  begin
    #(MAIN_HALF);
    if (main_osc_en === 1'b1) main_osc_in = ~main_osc_in;
  end
  always
  begin
    #(SUB_HALF);
    if (sub_osc_en === 1'b1) sub_osc_in = ~sub_osc_in;
  end
endmodule

// [verif/testbench.sv]
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic ext_irq = 1'b0;
  logic irq_accept = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic main_osc_in, sub_osc_in, main_osc_en, sub_osc_en, sub_pins_port_mode, phi, cpu_clk_held;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  int n_main = 0;
  int n_sub = 0;
  logic [31:0] seed = 32'd71081;

  clk_ctl i_clk_ctl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_osc_in, .sub_osc_in,
    .main_osc_en, .sub_osc_en, .sub_pins_port_mode, .ext_irq, .irq_accept, .phi, .cpu_clk_held);
  osc_model i_osc_model (.main_osc_en, .sub_osc_en, .main_osc_in, .sub_osc_in);

  always #20 aclk = ~aclk;
  always @(posedge main_osc_in) n_main++;
  always @(posedge sub_osc_in) n_sub++;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Pin edges in one internal clock period for a speed code
  function automatic int edges(input logic [1:0] spd);
    return (spd == 2'd1 || spd == 2'd2) ? 2 : 8;
  endfunction
  function automatic int rec_edges(input logic [7:0] p, input logic [7:0] t, input logic sub);
    return (sub ? 1 : 16) * (int'(p) + 1) * (int'(t) + 1);
  endfunction

  task automatic summarize();
    $display("checks %0d, failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    num_checks++;
    if (got !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", what, e, got);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = clk_ctl_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge aclk);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(what, {24'h00_0000, e}, d);
    chk("rresp", 32'(clk_ctl_pkg::RESP_OKAY), 32'(r));
  endtask
  task automatic wait_for(ref logic sig, input logic v, input int lim, input string what);
    int n;
    n = 0;
    while (sig !== v && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    chk(what, 32'(v), 32'(sig));
  endtask
  // Settle past a mode change, then count pin edges over one internal clock period
  task automatic meas(input logic [1:0] spd);
    int m0;
    int s0;
    repeat (3) @(posedge phi);
    m0 = n_main;
    s0 = n_sub;
    @(posedge phi);
    chk("phi period", edges(spd), (spd == 2'd2) ? n_sub - s0 : n_main - m0);
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] p;
    logic [7:0] t;
    int m0;
    int s0;
    int e;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("phi", 1, 32'(phi));
    chk("sub_osc_en", 0, 32'(sub_osc_en));
    chk("port mode", 1, 32'(sub_pins_port_mode));
    rchk(clk_ctl_pkg::IDX_MODE, clk_ctl_pkg::MODE_RST, "mode reg");
    rchk(clk_ctl_pkg::IDX_PRE, clk_ctl_pkg::PRE_RST, "prescaler");
    rchk(clk_ctl_pkg::IDX_TMR, clk_ctl_pkg::TMR_RST, "timer");
    rd(8'h00, d, r);
    chk("unmapped resp", 32'(clk_ctl_pkg::RESP_SLVERR), 32'(r));
    wr(8'h00, 8'h00, clk_ctl_pkg::RESP_SLVERR);
    meas(2'd0);
    for (int s = 0; s < 4; s++)
    begin
      wr(clk_ctl_pkg::IDX_MODE, {2'(s), 6'h10});
      meas(2'(s));
    end
    chk("port mode", 0, 32'(sub_pins_port_mode));
    wr(clk_ctl_pkg::IDX_MODE, 8'h90);
    meas(2'd2);
    wr(clk_ctl_pkg::IDX_MODE, 8'hB0);
    meas(2'd2);
    chk("main_osc_en", 0, 32'(main_osc_en));
    wr(clk_ctl_pkg::IDX_MODE, 8'h90);
    wait_for(main_osc_en, 1'b1, 8, "main restart");
    wr(clk_ctl_pkg::IDX_MODE, 8'h10);
    meas(2'd0);
    // First pass leaves stop by reset; the rest use random preloads and wake by interrupt
    for (int i = 0; i < 4; i++)
    begin
      p = 8'(rnd() % 3 + 1);
      t = 8'(rnd() % 3);
      wr(clk_ctl_pkg::IDX_PRE, p);
      wr(clk_ctl_pkg::IDX_TMR, t);
      // Last pass counts recovery on the sub oscillator, so it must be running
      if (i == 3) wr(clk_ctl_pkg::IDX_MODE, 8'h10);
      wr(clk_ctl_pkg::IDX_MISC, (i == 3) ? 8'h03 : {7'h00, i != 0});
      wr(clk_ctl_pkg::IDX_CMD, 8'h01);
      wait_for(main_osc_en, 1'b0, 400, "main stop");
      chk("sub in stop", 0, 32'(sub_osc_en));
      chk("phi in stop", 1, 32'(phi));
      rchk(clk_ctl_pkg::IDX_PRE, (i == 0) ? clk_ctl_pkg::PRE_STOP_LOAD : p, "stop prescaler");
      rchk(clk_ctl_pkg::IDX_TMR, (i == 0) ? clk_ctl_pkg::TMR_STOP_LOAD : t, "stop timer");
      if (i == 0)
      begin
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        wait_for(cpu_clk_held, 1'b0, 2, "reset exit");
        chk("main after reset", 1, 32'(main_osc_en));
      end
      else
      begin
        ext_irq <= 1'b1;
        m0 = n_main;
        s0 = n_sub;
        wait_for(cpu_clk_held, 1'b0, 4000, "recovery end");
        ext_irq <= 1'b0;
        m0 = (i == 3) ? n_sub - s0 : n_main - m0;
        e = rec_edges(p, t, i == 3);
        chk("recovery edges", e, (m0 >= e - 2 && m0 <= e + 2) ? e : m0);
      end
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(clk_ctl_pkg::IDX_CMD, 8'h02);
      wait_for(cpu_clk_held, 1'b1, 8, "wait entry");
      // A middle-speed low phase may need about 33 cycles to finish before the clock parks
      repeat (40) @(posedge aclk);
      chk("phi in wait", 1, 32'(phi));
      chk("main in wait", 1, 32'(main_osc_en));
      if (k == 0) irq_accept <= 1'b1;
      else ext_irq <= 1'b1;
      wait_for(cpu_clk_held, 1'b0, 8, "wait wake");
      irq_accept <= 1'b0;
      ext_irq <= 1'b0;
    end
    summarize();
  end
endmodule
